// [test/gsil_core_asserts.sv]
// Assertion checker for the gate safety input learning core
`timescale 1ns/100ps
module gsil_core_asserts (
  input wire       clk,
  input wire       resetn,
  input wire       halt_cmd,
  input wire       reverse_cmd,
  input wire       resume_cmd,
  input wire       learning,
  input wire [1:0] stop_class,
  input wire       bus_learn_led_a,
  input wire       bus_learn_led_b
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_halt_one_cycle: assert property (halt_cmd |=> !halt_cmd) else $error("halt held");
  a_reverse_holds: assert property ($rose(reverse_cmd) |-> reverse_cmd[*8]) else $error("reverse short");
  a_reverse_ends: assert property (reverse_cmd |-> ##[1:12] !reverse_cmd) else $error("reverse long");
  a_resume_pulse: assert property (resume_cmd |=> !resume_cmd) else $error("resume held");
  a_learn_quiet: assert property (learning |-> !halt_cmd && !resume_cmd) else $error("cmd in learn");
  a_leds_paired: assert property (bus_learn_led_a == bus_learn_led_b) else $error("leds differ");
  a_class_kept: assert property (!learning && !$past(learning) |-> $stable(stop_class)) else $error("moved");
  a_learn_span: assert property ($rose(learning) |-> learning[*8]) else $error("learn short");
  cover property ($rose(reverse_cmd));
  cover property (resume_cmd);
  cover property ($fell(learning));
endmodule
bind gsil_core gsil_core_asserts u_chk (.clk(clk), .resetn(resetn), .halt_cmd(halt_cmd), .reverse_cmd(reverse_cmd),
  .resume_cmd(resume_cmd), .learning(learning), .stop_class(stop_class), .bus_learn_led_a(bus_learn_led_a),
  .bus_learn_led_b(bus_learn_led_b));

// [test/gsil_far_side.sv]
// Far-side model: stop terminal device and bus photocells
`timescale 1ns/100ps
module gsil_far_side (
  input  wire [1:0] kind,
  input  wire       pressed,
  input  wire [7:0] fitted,
  input  wire [7:0] blocked,
  output wire [1:0] stop_level,
  output wire [7:0] bus_present,
  output wire [7:0] beam_blocked
);
  assign bus_present  = fitted;
  assign beam_blocked = blocked & fitted;
  // A tripped edge shorts the loop, as a NO contact would
  assign stop_level   = (kind == 2'h2) ? {1'b0, !pressed} : (kind == 2'h3) ? {!pressed, pressed} : {1'b0, pressed};
endmodule

// [test/testbench.sv]
// Self-checking bench for the gate safety input learning core
`timescale 1ns/100ps
module testbench;
  reg         clk = 1'b0, resetn = 1'b0, key_open = 1'b0, key_stop = 1'b0, pressed = 1'b0;
  reg  [1:0]  motion = 2'h0, kind = 2'h1;
  reg  [7:0]  funcs = 8'h00, fitted = 8'h3F, blocked = 8'h00;
  reg  [31:0] rnd;
  wire [1:0]  stop_level, stop_class;
  wire [7:0]  bus_present, beam_blocked, leds;
  wire        halt_cmd, reverse_cmd, resume_cmd, bus_anomaly, learning, stop_led, bus_learn_led_a, bus_learn_led_b;
  integer     bad_count = 0, n_compared = 0, cycles = 0, lit = 0, seen = 0, i;
  integer     exp_q[$];
  always #12.5 clk = ~clk;
  gsil_far_side far (.kind, .pressed, .fitted, .blocked, .stop_level, .bus_present, .beam_blocked);
  gsil_core #(.HOLD_CYC(20), .LEARN_CYC(20), .REV_CYC(10), .FAST_CYC(4), .SLOW_CYC(8)) uut (.clk, .resetn,
    .key_open, .key_stop, .stop_level, .bus_present, .beam_blocked, .motion, .function_states(funcs),
    .halt_cmd, .reverse_cmd, .resume_cmd, .bus_anomaly, .learning, .stop_class, .stop_led, .bus_learn_led_a,
    .bus_learn_led_b, .function_state_leds(leds));
  task check(input [31:0] got, input [31:0] exp);
    n_compared = n_compared + 1;
    bad_count = bad_count + (got !== exp);
    if (got !== exp) $display("[FAIL] %0t got %h exp %h", $time, got, exp);
  endtask
  // Reaction the rules ask of a beam: 6 stop and reverse, 5 pause and resume
  function integer react(input integer adr, input [1:0] mot);
    react = 0;
    if (mot == 2'h2 && adr < 4) react = 6;
    if (mot == 2'h1 && adr > 3) react = 6;
    if (mot == 2'h1 && (adr == 2 || adr == 3)) react = 5;
  endfunction
  task complete_run;
    if (cycles > 4000) bad_count = bad_count + 1;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task watch(input integer n);
    repeat (n) begin
      @(negedge clk);
      seen = seen | {halt_cmd, reverse_cmd, resume_cmd};
      lit = lit + bus_learn_led_a;
      cycles = cycles + 1;
      if (cycles > 4000) complete_run;
    end
  endtask
  task learn(input [1:0] k);
    kind = k;
    {key_open, key_stop} = 2'h3;
    watch(26);
    check(learning, 1);
    watch(24);
    {key_open, key_stop} = 2'h0;
    watch(12);
    check({stop_class, stop_led, bus_learn_led_a, bus_learn_led_b, bus_anomaly, leds}, {k, 4'h8, funcs});
  endtask
  initial begin
    rnd = $urandom(33);
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    watch(40);
    check({stop_class, lit > 4 && lit < 36}, 1);
    for (i = 1; i < 4; i = i + 1) begin
      rnd = $urandom;
      {funcs, fitted} = rnd[15:0] | 16'h003F;
      learn(i[1:0]);
      motion = 2'h2;
      seen = 0;
      pressed = 1'b1;
      exp_q.push_back((motion != 2'h0) ? 6 : 4);
      watch(8);
      pressed = 1'b0;
      watch(16);
      check(seen, exp_q.pop_front());
      motion = 2'h0;
    end
    for (i = 0; i < 12; i = i + 1) begin
      motion = (i < 6) ? 2'h1 : 2'h2;
      watch(4);
      seen = 0;
      blocked = 8'h01 << (i % 6);
      exp_q.push_back(react(i % 6, motion));
      watch(8);
      blocked = 8'h00;
      watch(24);
      check(seen, exp_q.pop_front());
    end
    fitted = fitted ^ 8'h80;
    lit = 0;
    watch(32);
    check({bus_anomaly, stop_class}, 7);
    check(lit > 4 && lit < 28, 1);
    complete_run;
  end
endmodule

// [verilog/gsil_core.v]
// Accessory input learning, stop handling and photocell reactions
// Notes on behaviour
// (RQ1) Stop trip during motion halts gate then commands short reverse movement.
// (RQ2) Learning classifies stop input as NO, NC or 8.2k resistor, stored.
// (RQ3) After learning, any stop level departing from reference issues halt.
// (RQ4) Learning records bus addresses present; later mismatch raises anomaly.
// (RQ5) External photocells act only while closing: stop then reverse.
// (RQ6) Bidirectional photocells: closing stop and reverse; opening pause then resume.
// (RQ7) Opening-phase photocells act only while opening: stop then reverse.
// (RQ8) Operator holds open and stop keys together until fast flash, then releases.
// (RQ9) After about 3 s of both keys, fast flash both LEDs and learn.
// (RQ10) Learning done: stop LED on, bus LEDs off, function LEDs show states.
// (RQ11) Bus LEDs flash slowly on device-set mismatch or when never learned.
// (RQ12) Learned class and device set retained until next learning.
`timescale 1ns/100ps
`include "gsil_defs.vh"
module gsil_core #(
  parameter NADR      = 8,
  parameter HOLD_CYC  = `GSIL_HOLD_CYC,
  parameter REV_CYC   = `GSIL_REV_CYC,
  parameter LEARN_CYC = `GSIL_LEARN_CYC,
  parameter FAST_CYC  = `GSIL_FAST_HALF_CYC,
  parameter SLOW_CYC  = `GSIL_SLOW_HALF_CYC
) (
  input  wire            clk,
  input  wire            resetn,
  input  wire            key_open,
  input  wire            key_stop,
  input  wire [1:0]      stop_level,
  input  wire [NADR-1:0] bus_present,
  input  wire [NADR-1:0] beam_blocked,
  input  wire [1:0]      motion,
  input  wire [7:0]      function_states,
  output reg             halt_cmd,
  output reg             reverse_cmd,
  output reg             resume_cmd,
  output reg             bus_anomaly,
  output reg             learning,
  output reg  [1:0]      stop_class,
  output reg             stop_led,
  output reg             bus_learn_led_a,
  output reg             bus_learn_led_b,
  output reg  [7:0]      function_state_leds
);
  localparam ST_RUN   = 2'h0;
  localparam ST_HOLD  = 2'h1;
  localparam ST_LEARN = 2'h2;
  localparam ST_WAITR = 2'h3;

  wire [1:0]      lvl_s;
  wire [NADR-1:0] pres_s;
  wire [NADR-1:0] beam_s;
  wire [1:0]      keys_s;
  gsil_sync #(.W(2 + 2 * NADR + 2)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      ({key_open, key_stop, beam_blocked, bus_present, stop_level}),
    .q      ({keys_s, beam_s, pres_s, lvl_s})
  );

  reg [1:0]      state_q;
  reg [31:0]     cnt_q;
  reg [31:0]     blink_q;
  reg            blink_q2;
  reg            learned_q;
  reg [NADR-1:0] set_q;
  reg            rhit_q;
  reg [31:0]     rev_q;
  reg            paused_q;
  reg            trip_q;

  // Reference level expected for each learned class
  function [1:0] cls_ref;
    input [1:0] c;
    begin
      case (c)
        `GSIL_CLS_NO:  cls_ref = `GSIL_LVL_OPEN;
        `GSIL_CLS_NC:  cls_ref = `GSIL_LVL_SHORT;
        default:       cls_ref = `GSIL_LVL_RES;
      endcase
    end
  endfunction

  wire both_keys = keys_s[1] & keys_s[0];
  wire closing   = (motion == `GSIL_MOV_CLOSE);
  wire opening   = (motion == `GSIL_MOV_OPEN);
  wire moving    = closing | opening;
  // Stop trip counts only once something was learned on the input
  wire stop_dev  = learned_q && (stop_class != `GSIL_CLS_NONE) && (lvl_s != cls_ref(stop_class)); // [RQ3]
  wire ext_hit   = closing & (beam_s[`GSIL_ADR_EXT_LOW] | beam_s[`GSIL_ADR_EXT_HIGH]); // [RQ5]
  wire bid_hit   = beam_s[`GSIL_ADR_BID_LOW] | beam_s[`GSIL_ADR_BID_HIGH];
  wire opn_hit   = opening & (beam_s[`GSIL_ADR_OPN_A] | beam_s[`GSIL_ADR_OPN_B]); // [RQ7]
  wire rev_hit   = ext_hit | opn_hit | (closing & bid_hit); // [RQ6]
  wire blk       = (state_q == ST_LEARN) || (state_q == ST_WAITR);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q             <= ST_RUN;
      cnt_q               <= 32'h0;
      blink_q             <= 32'h0;
      blink_q2            <= 1'b0;
      learned_q           <= 1'b0;
      set_q               <= {NADR{1'b0}};
      rhit_q              <= 1'b0;
      stop_class          <= `GSIL_CLS_NONE;
      rev_q               <= 32'h0;
      paused_q            <= 1'b0;
      trip_q              <= 1'b0;
      halt_cmd            <= 1'b0;
      reverse_cmd         <= 1'b0;
      resume_cmd          <= 1'b0;
      bus_anomaly         <= 1'b0;
      learning            <= 1'b0;
      stop_led            <= 1'b0;
      bus_learn_led_a     <= 1'b0;
      bus_learn_led_b     <= 1'b0;
      function_state_leds <= 8'h00;
    end else begin
      // Shared blink timer, fast during learning and the wait for key release, slow otherwise
      if (blink_q >= (blk ? FAST_CYC - 1 : SLOW_CYC - 1)) begin
        blink_q  <= 32'h0;
        blink_q2 <= ~blink_q2;
      end else begin
        blink_q <= blink_q + 32'h1;
      end
      halt_cmd   <= 1'b0;
      resume_cmd <= 1'b0;
      case (state_q)
        ST_RUN: begin
          cnt_q <= 32'h0;
          if (both_keys) state_q <= ST_HOLD; // [RQ8]
        end
        ST_HOLD: begin
          if (!both_keys) begin
            state_q <= ST_RUN;
          end else if (cnt_q >= HOLD_CYC - 1) begin
            state_q <= ST_LEARN; // [RQ9]
            cnt_q   <= 32'h0;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        ST_LEARN: begin
          // Settle period lets bus devices answer before sampling
          if (cnt_q >= LEARN_CYC - 1) begin
            state_q   <= ST_WAITR;
            learned_q <= 1'b1; // [RQ12]
            set_q     <= pres_s; // [RQ4]
            case (lvl_s) // [RQ2]
              `GSIL_LVL_OPEN:  stop_class <= `GSIL_CLS_NO;
              `GSIL_LVL_SHORT: stop_class <= `GSIL_CLS_NC;
              `GSIL_LVL_RES:   stop_class <= `GSIL_CLS_RES;
              default:         stop_class <= `GSIL_CLS_NONE;
            endcase
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        default: begin
          // Keys still held after learning must not retrigger it
          if (!keys_s[1] && !keys_s[0]) state_q <= ST_RUN;
        end
      endcase

      learning    <= (state_q == ST_LEARN);
      bus_anomaly <= learned_q && (pres_s != set_q); // [RQ4]
      stop_led    <= learned_q && !stop_dev; // [RQ10]
      if (state_q == ST_LEARN) begin
        bus_learn_led_a <= blink_q2; // [RQ9]
        bus_learn_led_b <= blink_q2;
      end else if (!learned_q || (pres_s != set_q)) begin
        bus_learn_led_a <= blink_q2; // [RQ11]
        bus_learn_led_b <= blink_q2;
      end else begin
        bus_learn_led_a <= 1'b0; // [RQ10]
        bus_learn_led_b <= 1'b0;
      end
      function_state_leds <= function_states; // [RQ10]

      // Halt on stop deviation, one pulse per event
      trip_q <= stop_dev;
      if (stop_dev && !trip_q) halt_cmd <= 1'b1; // [RQ3]
      // Reverse pulse held for the brief reversal window
      if (rev_q != 32'h0) begin
        rev_q <= rev_q - 32'h1;
        if (rev_q == 32'h1) reverse_cmd <= 1'b0;
      end
      // Beams act on their leading edge so a held beam gives one halt
      rhit_q <= rev_hit && !blk;
      if ((stop_dev && !trip_q && moving) || (rev_hit && !blk && !rhit_q)) begin
        halt_cmd    <= 1'b1; // [RQ1]
        reverse_cmd <= 1'b1; // [RQ1]
        rev_q       <= REV_CYC;
      end
      // Bidirectional beam while opening pauses, then resumes
      if (opening && bid_hit && !blk && !paused_q) begin
        halt_cmd <= 1'b1; // [RQ6]
        paused_q <= 1'b1;
      end else if (paused_q && !bid_hit) begin
        resume_cmd <= 1'b1; // [RQ6]
        paused_q   <= 1'b0;
      end
    end
  end
endmodule

// [verilog/gsil_defs.vh]
// Constants for the gate safety input learning block
`ifndef GSIL_DEFS_VH
`define GSIL_DEFS_VH
`define GSIL_CLK_HZ          40000000
`define GSIL_HOLD_MS         3000
`define GSIL_HOLD_CYC        ((`GSIL_CLK_HZ / 1000) * `GSIL_HOLD_MS)
`define GSIL_REV_MS          500
`define GSIL_REV_CYC         ((`GSIL_CLK_HZ / 1000) * `GSIL_REV_MS)
`define GSIL_LEARN_MS        2000
`define GSIL_LEARN_CYC       ((`GSIL_CLK_HZ / 1000) * `GSIL_LEARN_MS)
`define GSIL_FAST_HALF_MS    100
`define GSIL_FAST_HALF_CYC   ((`GSIL_CLK_HZ / 1000) * `GSIL_FAST_HALF_MS)
`define GSIL_SLOW_HALF_MS    500
`define GSIL_SLOW_HALF_CYC   ((`GSIL_CLK_HZ / 1000) * `GSIL_SLOW_HALF_MS)
// Stop input classes
`define GSIL_CLS_NONE        2'h0
`define GSIL_CLS_NO          2'h1
`define GSIL_CLS_NC          2'h2
`define GSIL_CLS_RES         2'h3
// Stop input level codes from the analog front end
`define GSIL_LVL_OPEN        2'h0
`define GSIL_LVL_SHORT       2'h1
`define GSIL_LVL_RES         2'h2
// Bus addresses of the photocells in the presence map
`define GSIL_ADR_EXT_LOW     0
`define GSIL_ADR_EXT_HIGH    1
`define GSIL_ADR_BID_LOW     2
`define GSIL_ADR_BID_HIGH    3
`define GSIL_ADR_OPN_A       4
`define GSIL_ADR_OPN_B       5
// Motion codes
`define GSIL_MOV_IDLE        2'h0
`define GSIL_MOV_OPEN        2'h1
`define GSIL_MOV_CLOSE       2'h2
`endif

// [verilog/gsil_sync.v]
// Two-flop synchroniser for a bus of asynchronous inputs
`timescale 1ns/100ps
module gsil_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         resetn,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
